// File: hdl/pin_cfg_pkg.sv
package pin_cfg_pkg;

  // Serial frame layout: read flag, register address, register data
  localparam int             FRAME_BITS = 24;
  localparam int             RW_BIT     = 23;
  localparam int             ADDR_HI    = 22;
  localparam int             ADDR_LO    = 16;
  localparam int             DATA_W     = 16;
  localparam logic [4:0]     LAST_BIT   = 5'h17;
  localparam logic [4:0]     FIRST_BIT  = 5'h00;
  localparam logic [4:0]     BIT_STEP   = 5'h01;

  // Register offsets
  localparam logic [6:0]     SERIAL_OUT_CONTROL_ADDR    = 7'h08;
  localparam logic [6:0]     GENERAL_CONFIGURATION_ADDR = 7'h09;

  // Reset values and writable-bit masks
  localparam logic [15:0]    SERIAL_OUT_CONTROL_RESET    = 16'h0000;
  localparam logic [15:0]    GENERAL_CONFIGURATION_RESET = 16'h0014;
  localparam logic [15:0]    SERIAL_OUT_CONTROL_MASK     = 16'h0003;
  localparam logic [15:0]    GENERAL_CONFIGURATION_MASK  = 16'h0035;
  localparam logic [15:0]    UNMAPPED_READ               = 16'h0000;

  // Field positions of serial_out_control
  localparam int             OUT_DRIVER_ENABLE_BIT = 0;
  localparam int             EARLY_OUT_SHIFT_BIT   = 1;

  // Field positions of general_configuration
  localparam int             PIN_FUNCTION_SELECT_BIT  = 0;
  localparam int             REFERENCE_POWER_DOWN_BIT = 2;
  localparam int             PIN_DRIVE_TYPE_BIT       = 4;
  localparam int             PIN_POLARITY_BIT         = 5;

  // Synchronised pin indices and their idle levels
  localparam int             PIN_COUNT  = 4;
  localparam int             PIN_SCLK   = 0;
  localparam int             PIN_CS_N   = 1;
  localparam int             PIN_SDI    = 2;
  localparam int             PIN_DUAL   = 3;
  localparam logic [3:0]     PIN_IDLE   = 4'hA;

  // Frame sequencer states, gray along idle, shift, hold
  typedef enum logic [1:0] {
    FRAME_IDLE  = 2'h0,
    FRAME_SHIFT = 2'h1,
    FRAME_HOLD  = 2'h3
  } frame_state_t;

endpackage

// File: hdl/pin_sync.sv
module pin_sync #(
  parameter int                               WIDTH      = pin_cfg_pkg::PIN_COUNT,
  parameter logic [pin_cfg_pkg::PIN_COUNT-1:0] IDLE_LEVEL = pin_cfg_pkg::PIN_IDLE
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  // Raw pins from outside the clock domain
  input  wire logic [WIDTH-1:0] pins_i,
  // Filtered levels and edges
  pin_sync_if.src               sync
);

  logic [WIDTH-1:0] s1_q, s1_d;    // First stage, read only by the second
  logic [WIDTH-1:0] s2_q, s2_d;    // Second stage
  logic [WIDTH-1:0] s3_q, s3_d;    // Third stage
  logic [WIDTH-1:0] lvl_q, lvl_d;  // Accepted level

  // Next values of the three-stage chain
  always_comb begin
    s1_d = pins_i;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Per pin: a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      // One driver per bit, so no bit of the next-level vector has two drivers
      assign lvl_d[g]     = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      assign sync.rise[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !lvl_q[g];
      assign sync.fall[g] = (s2_q[g] == s3_q[g]) && !s3_q[g] && lvl_q[g];
    end
  endgenerate

  assign sync.level = lvl_q;

  // Registers start at the idle level so reset makes no false edge
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s1_q  <= IDLE_LEVEL;
      s2_q  <= IDLE_LEVEL;
      s3_q  <= IDLE_LEVEL;
      lvl_q <= IDLE_LEVEL;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

endmodule

// File: hdl/pin_sync_if.sv
interface pin_sync_if;
  logic [pin_cfg_pkg::PIN_COUNT-1:0] level;  // Filtered pin level
  logic [pin_cfg_pkg::PIN_COUNT-1:0] rise;   // One-cycle rising edge
  logic [pin_cfg_pkg::PIN_COUNT-1:0] fall;   // One-cycle falling edge
  modport src (output level, rise, fall);
  modport dst (input level, rise, fall);
endinterface

// File: hdl/serial_out_and_pin_config.sv
// What this block does
// RULE_01 - Serial-output control at 8h, resets 0000h
// RULE_02 - General configuration at 9h, resets 0014h
// RULE_03 - Driver enable drives SDO while select low
// RULE_04 - I2C mode never drives SDO
// RULE_05 - SDI always sampled on SCLK falling edge
// RULE_06 - Normal mode: MSB at select, shift on rise
// RULE_07 - Early mode: MSB at select, shift on fall
// RULE_08 - Early shift ignored while driver disabled
// RULE_09 - Polarity 0: data 0 low, 1 high/float
// RULE_10 - Polarity 1: output inverted
// RULE_11 - Drive type: 0 push-pull, 1 open-drain
// RULE_12 - Drive type ignored unless pin outputs
// RULE_13 - Reference power-down bit, resets to 1
// RULE_14 - Function 0: pin follows general-purpose data
// RULE_15 - Function 1: pin is active-low clear input
// RULE_16 - Reserved bits read zero, writes ignored
module serial_out_and_pin_config (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  // Serial port pins
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  // Interface mode strap level, high in I2C operation
  input  wire logic i2c_mode_i,
  // Dual-purpose pin
  input  wire logic dual_purpose_pin_i,
  output logic      dual_purpose_pin_o,
  output logic      dual_purpose_pin_oe_o,
  // General-purpose data value, bit 0 of its register
  input  wire logic gpio_data_i,
  // Block controls
  output logic      clear_active_o,
  output logic      reference_power_down_o
);

  pin_sync_if sync ();  // Filtered pin levels and edges

  // Pin synchroniser for clock, select, data in and dual-purpose pin
  pin_sync #(
    .WIDTH      (pin_cfg_pkg::PIN_COUNT),
    .IDLE_LEVEL (pin_cfg_pkg::PIN_IDLE)
  ) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .pins_i   ({dual_purpose_pin_i, sdi_i, cs_n_i, sclk_i}),
    .sync     (sync.src)
  );

  pin_cfg_pkg::frame_state_t state_q, state_d;  // Frame sequencer
  logic [4:0]  cnt_q, cnt_d;                     // Bits taken in this frame
  logic [23:0] rx_q, rx_d;                       // Incoming frame
  logic [23:0] tx_q, tx_d;                       // Answer for the next frame
  logic [23:0] sh_q, sh_d;                       // Outgoing shift register
  logic [15:0] soc_q, soc_d;                     // serial_out_control
  logic [15:0] gen_q, gen_d;                     // general_configuration
  logic        pin_q, pin_d;                     // Dual pin output value
  logic        pin_oe_q, pin_oe_d;               // Dual pin output enable
  logic        clr_q, clr_d;                     // Clear request level
  logic [23:0] word;                             // Frame with the last bit
  logic [6:0]  addr;                             // Decoded address
  logic [15:0] rdata;                            // Read-back value
  logic        drv_en;                           // Driver enable bit
  logic        early;                            // Effective early shift
  logic        gpio_lvl;                         // Polarity-adjusted data

  assign drv_en = soc_q[pin_cfg_pkg::OUT_DRIVER_ENABLE_BIT];
  // Early shift means nothing while the driver is off
  assign early  = drv_en && soc_q[pin_cfg_pkg::EARLY_OUT_SHIFT_BIT];  // RULE_08
  assign word   = {rx_q[22:0], sync.level[pin_cfg_pkg::PIN_SDI]};
  assign addr   = word[pin_cfg_pkg::ADDR_HI:pin_cfg_pkg::ADDR_LO];

  // Read mux; unmapped offsets answer zero
  always_comb begin
    unique case (addr)
      pin_cfg_pkg::SERIAL_OUT_CONTROL_ADDR:    rdata = soc_q;  // RULE_01
      pin_cfg_pkg::GENERAL_CONFIGURATION_ADDR: rdata = gen_q;  // RULE_02
      default:                                 rdata = pin_cfg_pkg::UNMAPPED_READ;
    endcase
  end

  // Frame sequencer and register writes
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    sh_d    = sh_q;
    soc_d   = soc_q;
    gen_d   = gen_q;
    unique case (state_q)
      pin_cfg_pkg::FRAME_IDLE: begin
        // Frames are ignored in I2C operation
        if (sync.fall[pin_cfg_pkg::PIN_CS_N] && !i2c_mode_i) begin
          state_d = pin_cfg_pkg::FRAME_SHIFT;
          cnt_d   = pin_cfg_pkg::FIRST_BIT;
          sh_d    = tx_q;  // MSB stands from select fall RULE_06 RULE_07
        end
      end
      pin_cfg_pkg::FRAME_SHIFT: begin
        // Data in is taken on the falling clock edge only
        if (sync.fall[pin_cfg_pkg::PIN_SCLK]) begin
          rx_d  = word;  // RULE_05
          cnt_d = cnt_q + pin_cfg_pkg::BIT_STEP;
          if (cnt_q == pin_cfg_pkg::LAST_BIT) begin
            state_d = pin_cfg_pkg::FRAME_HOLD;
            if (word[pin_cfg_pkg::RW_BIT]) begin
              tx_d = {word[pin_cfg_pkg::RW_BIT:pin_cfg_pkg::ADDR_LO], rdata};
            end else if (addr == pin_cfg_pkg::SERIAL_OUT_CONTROL_ADDR) begin
              soc_d = word[15:0] & pin_cfg_pkg::SERIAL_OUT_CONTROL_MASK;  // RULE_16
            end else if (addr == pin_cfg_pkg::GENERAL_CONFIGURATION_ADDR) begin
              gen_d = word[15:0] & pin_cfg_pkg::GENERAL_CONFIGURATION_MASK;  // RULE_16
            end
          end
        end
        // Early mode moves on the sampling edge itself
        if (early && sync.fall[pin_cfg_pkg::PIN_SCLK]) begin
          sh_d = {sh_q[22:0], 1'b0};  // RULE_07
        end
        // Normal mode waits for the first sample so the MSB is not lost
        if (!early && sync.rise[pin_cfg_pkg::PIN_SCLK] &&
            cnt_q != pin_cfg_pkg::FIRST_BIT) begin
          sh_d = {sh_q[22:0], 1'b0};  // RULE_06
        end
      end
      pin_cfg_pkg::FRAME_HOLD: begin
        // Extra clocks after a full frame are ignored
        cnt_d = cnt_q;
      end
      default: begin
        state_d = pin_cfg_pkg::FRAME_IDLE;
      end
    endcase
    // Select rising ends any frame; a short one is dropped
    if (sync.rise[pin_cfg_pkg::PIN_CS_N]) begin
      state_d = pin_cfg_pkg::FRAME_IDLE;
    end
  end

  // Registered frame and configuration state
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_q <= pin_cfg_pkg::FRAME_IDLE;
      cnt_q   <= pin_cfg_pkg::FIRST_BIT;
      rx_q    <= '0;
      tx_q    <= '0;
      sh_q    <= '0;
      soc_q   <= pin_cfg_pkg::SERIAL_OUT_CONTROL_RESET;     // RULE_01
      gen_q   <= pin_cfg_pkg::GENERAL_CONFIGURATION_RESET;  // RULE_02 RULE_13
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      sh_q    <= sh_d;
      soc_q   <= soc_d;
      gen_q   <= gen_d;
    end
  end

  // Driver only while enabled, select low and not in I2C operation
  assign sdo_o    = sh_q[23];
  assign sdo_oe_o = drv_en && !i2c_mode_i &&
                    !sync.level[pin_cfg_pkg::PIN_CS_N];  // RULE_03 RULE_04

  // Dual-purpose pin next values
  always_comb begin
    gpio_lvl = gpio_data_i ^ gen_q[pin_cfg_pkg::PIN_POLARITY_BIT];  // RULE_09 RULE_10
    clr_d    = 1'b0;
    if (gen_q[pin_cfg_pkg::PIN_FUNCTION_SELECT_BIT]) begin
      // Clear input: never driven, drive type has no effect
      pin_d    = 1'b0;  // RULE_12
      pin_oe_d = 1'b0;
      clr_d    = !sync.level[pin_cfg_pkg::PIN_DUAL];  // RULE_15
    end else if (gen_q[pin_cfg_pkg::PIN_DRIVE_TYPE_BIT]) begin
      // Open-drain: pull low or release
      pin_d    = 1'b0;  // RULE_11
      pin_oe_d = !gpio_lvl;
    end else begin
      // Push-pull from the general-purpose data
      pin_d    = gpio_lvl;  // RULE_14
      pin_oe_d = 1'b1;
    end
  end

  // Pin outputs come from flops; reset releases the pin
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pin_q    <= 1'b0;
      pin_oe_q <= 1'b0;
      clr_q    <= 1'b0;
    end else begin
      pin_q    <= pin_d;
      pin_oe_q <= pin_oe_d;
      clr_q    <= clr_d;
    end
  end

  assign dual_purpose_pin_o     = pin_q;
  assign dual_purpose_pin_oe_o  = pin_oe_q;
  assign clear_active_o         = clr_q;
  assign reference_power_down_o = gen_q[pin_cfg_pkg::REFERENCE_POWER_DOWN_BIT];  // RULE_13

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  a_soc_reset_value: assert property (  // RULE_01
    !$past(resetn_i) |-> soc_q == pin_cfg_pkg::SERIAL_OUT_CONTROL_RESET)
    else $error("serial_out_control reset value wrong");
  a_gen_reset_value: assert property (  // RULE_02
    !$past(resetn_i) |-> gen_q == pin_cfg_pkg::GENERAL_CONFIGURATION_RESET &&
                         reference_power_down_o)
    else $error("general_configuration reset value wrong");
  a_sdo_drive_when: assert property (  // RULE_03
    state_q != pin_cfg_pkg::FRAME_IDLE && !i2c_mode_i
    |-> sdo_oe_o == soc_q[pin_cfg_pkg::OUT_DRIVER_ENABLE_BIT])
    else $error("SDO enable does not follow enable and select");
  a_sdo_off_i2c: assert property (  // RULE_04
    i2c_mode_i |-> !sdo_oe_o)
    else $error("SDO driven in I2C operation");
  a_sdi_fall_only: assert property (  // RULE_05
    !sync.fall[pin_cfg_pkg::PIN_SCLK] |=> rx_q == $past(rx_q))
    else $error("SDI taken without a falling clock edge");
  a_msb_at_select: assert property (  // RULE_06
    state_q == pin_cfg_pkg::FRAME_IDLE && sync.fall[pin_cfg_pkg::PIN_CS_N] && !i2c_mode_i
    |=> sh_q == $past(tx_q))
    else $error("MSB not loaded at select fall");
  a_slow_no_fall: assert property (  // RULE_06
    state_q == pin_cfg_pkg::FRAME_SHIFT && !early && !sync.rise[pin_cfg_pkg::PIN_SCLK]
    |=> sh_q == $past(sh_q))
    else $error("Normal mode shifted off the rising edge");
  a_fast_shift: assert property (  // RULE_07
    state_q == pin_cfg_pkg::FRAME_SHIFT && early && sync.fall[pin_cfg_pkg::PIN_SCLK]
    |=> sh_q == {$past(sh_q[22:0]), 1'b0})
    else $error("Early mode did not shift on the falling edge");
  a_early_ignored: assert property (  // RULE_08
    state_q == pin_cfg_pkg::FRAME_SHIFT && !soc_q[pin_cfg_pkg::OUT_DRIVER_ENABLE_BIT] &&
    sync.fall[pin_cfg_pkg::PIN_SCLK] |=> sh_q == $past(sh_q))
    else $error("Early shift active with driver off");
  a_gpio_push_pull: assert property (  // RULE_09
    $past(resetn_i) && !$past(gen_q[pin_cfg_pkg::PIN_FUNCTION_SELECT_BIT]) &&
    !$past(gen_q[pin_cfg_pkg::PIN_DRIVE_TYPE_BIT])
    |-> dual_purpose_pin_oe_o &&
        dual_purpose_pin_o == ($past(gpio_data_i) ^
                               $past(gen_q[pin_cfg_pkg::PIN_POLARITY_BIT])))
    else $error("Push-pull pin level wrong");
  a_gpio_open_drain: assert property (  // RULE_11
    $past(resetn_i) && !$past(gen_q[pin_cfg_pkg::PIN_FUNCTION_SELECT_BIT]) &&
    $past(gen_q[pin_cfg_pkg::PIN_DRIVE_TYPE_BIT])
    |-> !dual_purpose_pin_o &&
        dual_purpose_pin_oe_o == ($past(gpio_data_i) ==
                                  $past(gen_q[pin_cfg_pkg::PIN_POLARITY_BIT])))
    else $error("Open-drain pin level wrong");
  a_clear_input: assert property (  // RULE_15
    $past(resetn_i) && $past(gen_q[pin_cfg_pkg::PIN_FUNCTION_SELECT_BIT])
    |-> !dual_purpose_pin_oe_o &&
        clear_active_o == !$past(sync.level[pin_cfg_pkg::PIN_DUAL]))
    else $error("Clear input handling wrong");
  a_reserved_zero: assert property (  // RULE_16
    (soc_q & ~pin_cfg_pkg::SERIAL_OUT_CONTROL_MASK) == 16'h0000 &&
    (gen_q & ~pin_cfg_pkg::GENERAL_CONFIGURATION_MASK) == 16'h0000)
    else $error("Reserved bit set");

  c_frame_done: cover property (state_q == pin_cfg_pkg::FRAME_SHIFT ##1
                                state_q == pin_cfg_pkg::FRAME_HOLD);
  c_early_drive: cover property (early && sdo_oe_o && sync.fall[pin_cfg_pkg::PIN_SCLK]);
  c_clear_seen: cover property (clear_active_o);
  c_open_drain_low: cover property (dual_purpose_pin_oe_o &&
                                    gen_q[pin_cfg_pkg::PIN_DRIVE_TYPE_BIT]);

endmodule

// File: tb/spi_host_model.sv
// Serial host on the far side of the link, paced off the system clock
module spi_host_model (
  // System clock, used only to pace the link
  input  wire logic mclk_i,
  // Resolved level of the serial data out line
  input  wire logic sdo_line_i,
  // Host-driven serial pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Link clock stands still low between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // One frame MSB first, 8 mclk per link clock; nbits below 24 cuts it short
  task automatic xfer(input logic [23:0] tx, input logic early, input int nbits,
                      output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    // Leave time for the synchronised select before the first edge
    repeat (20) @(negedge mclk_i);
    for (int i = 23; i > 23 - nbits; i--) begin
      // Wrong level up to the rise: a device sampling on the rise takes it
      sdi_o = ~tx[i];
      @(negedge mclk_i);
      // Normal shift: previous bit read just before this rise moves it
      if (!early && i < 23) rx[i + 1] = sdo_line_i;
      sclk_o = 1'b1;
      @(negedge mclk_i);
      // True bit from just after the rise until the next bit, so only a falling-edge sample sees it
      sdi_o = tx[i];
      repeat (2) @(negedge mclk_i);
      // Early shift moves SDO at falls, so read it three mclk into the high phase, one before the fall
      if (early) rx[i] = sdo_line_i;
      @(negedge mclk_i);
      sclk_o = 1'b0;
      repeat (3) @(negedge mclk_i);
    end
    // Last bit of a normal-shift frame, one half period after the last fall
    @(negedge mclk_i);
    if (!early) rx[24 - nbits] = sdo_line_i;
    // Data line no longer holds its last bit once the frame is over
    sdi_o = ~sdi_o;
    repeat (8) @(negedge mclk_i);
    cs_n_o = 1'b1;
    repeat (12) @(negedge mclk_i);
  endtask
endmodule

// File: tb/test_serial_out_and_pin_config.sv
// Register bank bench: every frame goes through the host model
module test_serial_out_and_pin_config;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk      = 1'b0;  // 20 MHz system clock
  logic resetn    = 1'b0;  // Held low at start
  logic i2c_mode  = 1'b0;  // Interface strap
  logic ext_level = 1'b1;  // Level the outside party puts on the dual pin
  logic gpio_data = 1'b0;  // General-purpose data bit
  logic oe_seen   = 1'b0;  // SDO driver seen enabled
  logic sclk, cs_n, sdi, sdo, sdo_oe, sdo_line;
  logic pin_in, pin_out, pin_oe, clear_active, ref_pd;
  int   n_errors  = 0;
  int   checks    = 0;

  // Clock and driver monitor
  always #25 mclk = ~mclk;
  always @(posedge mclk) if (sdo_oe === 1'b1) oe_seen <= 1'b1;

  // Wire levels: released SDO shows the inverse, not a stale bit;
  // dual pin shows the outside party's ext_level when undriven
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  assign pin_in   = pin_oe ? pin_out : ext_level;

  serial_out_and_pin_config dut_u (
    .mclk_i(mclk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .i2c_mode_i(i2c_mode), .dual_purpose_pin_i(pin_in),
    .dual_purpose_pin_o(pin_out), .dual_purpose_pin_oe_o(pin_oe), .gpio_data_i(gpio_data),
    .clear_active_o(clear_active), .reference_power_down_o(ref_pd));

  spi_host_model host_u (
    .mclk_i(mclk), .sdo_line_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [23:0] rx;
    host_u.xfer({1'b0, a, d}, 1'b0, 24, rx);
  endtask

  // Read takes two frames: the request, then the frame that carries the answer
  task automatic rd(input logic [6:0] a, input logic early, input logic [15:0] exp);
    logic [23:0] rx;
    host_u.xfer({1'b1, a, 16'h0000}, early, 24, rx);
    host_u.xfer({1'b1, a, 16'h0000}, early, 24, rx);
    check(rx, {1'b1, a, exp});
  endtask

  // Outputs straight after reset; driver stays off with enable at reset value
  task automatic t_reset_state();
    logic [23:0] rx;
    check(24'(ref_pd), 24'h000001);
    check(24'({pin_oe, pin_out}), 24'h000002);
    host_u.xfer({1'b1, 7'h09, 16'h0000}, 1'b0, 24, rx);
    check(24'(oe_seen), 24'h000000);
  endtask

  // Enable with reserved bits set, then normal-edge reads
  task automatic t_normal();
    wr(7'h08, 16'hFFFD);
    oe_seen = 1'b0;
    rd(7'h08, 1'b0, 16'h0001);
    check(24'(oe_seen), 24'h000001);
    check(24'(sdo_oe), 24'h000000);
    rd(7'h09, 1'b0, 16'h0014);
    rd(7'h0A, 1'b0, 16'h0000);
  endtask

  // Early shift, then early shift alone with the driver off
  task automatic t_early();
    wr(7'h08, 16'h0003);
    rd(7'h09, 1'b1, 16'h0014);
    wr(7'h08, 16'h0002);
    oe_seen = 1'b0;
    wr(7'h09, 16'h0014);
    check(24'(oe_seen), 24'h000000);
    wr(7'h08, 16'h0001);
  endtask

  // Strapped to I2C: no driver, and SPI writes have no effect
  task automatic t_i2c();
    i2c_mode = 1'b1;
    oe_seen  = 1'b0;
    wr(7'h09, 16'h0000);
    check(24'(oe_seen), 24'h000000);
    check(24'(ref_pd), 24'h000001);
    i2c_mode = 1'b0;
  endtask

  // Frame cut after 12 bits must not write
  task automatic t_abort();
    logic [23:0] rx;
    host_u.xfer({1'b0, 7'h09, 16'h0000}, 1'b0, 12, rx);
    check(24'(ref_pd), 24'h000001);
  endtask

  // Reserved configuration bits, then reference enabled
  task automatic t_reserved();
    wr(7'h09, 16'hFFFF);
    rd(7'h09, 1'b0, 16'h0035);
    wr(7'h09, 16'h0000);
    check(24'(ref_pd), 24'h000000);
  endtask

  // Every polarity, drive type and data value as general-purpose output
  task automatic t_pin_table();
    logic lv;
    for (int m = 0; m < 8; m++) begin
      wr(7'h09, {10'h000, m[2], m[1], 4'h0});
      gpio_data = m[0];
      repeat (3) @(negedge mclk);
      lv = m[0] ^ m[2];
      if (m[1]) check(24'({pin_oe, pin_out}), 24'({~lv, 1'b0}));
      else check(24'({pin_oe, pin_out}), 24'({1'b1, lv}));
    end
  endtask

  // Clear input: pin released even with push-pull selected, low level acts
  task automatic t_clear();
    wr(7'h09, 16'h0021);
    check(24'({pin_oe, clear_active}), 24'h000000);
    ext_level = 1'b0;
    for (int k = 0; k < 10 && clear_active !== 1'b1; k++) @(negedge mclk);
    check(24'(clear_active), 24'h000001);
    ext_level = 1'b1;
    for (int k = 0; k < 10 && clear_active !== 1'b0; k++) @(negedge mclk);
    check(24'(clear_active), 24'h000000);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset_state();
    t_normal();
    t_early();
    t_i2c();
    t_abort();
    t_reserved();
    t_pin_table();
    t_clear();
    end_of_test();
  end

  // Hang guard well above the expected run length
  initial begin
    #2000000;
    n_errors++;
    $display("MISMATCH at %0t: run timed out", $time);
    end_of_test();
  end
endmodule
